// ---- hpc_host.sv ----
// Purpose: host controller model driving the register port
// Assumes: requests launched just after a rising edge of core_clk
// Notes:   address and data parked inverted between requests
module hpc_host (
    // clock
    input  wire logic       core_clk,
    // register port
    output logic            reg_wr = 1'b0,
    output logic            reg_rd = 1'b0,
    output logic [7:0]      reg_addr = 8'h00,
    output logic [7:0]      reg_wdata = 8'h00,
    input  wire logic [7:0] reg_rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr <= 1'b0;
        reg_addr <= ~a;
        reg_wdata <= ~d;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge core_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        reg_addr <= ~a;
        #1 d = reg_rdata;
    endtask
    // loop computation kept opposite to the custom wave choice
    task automatic set_wave(input logic [7:0] opts, input logic accel);
        wr(8'h24, opts);
        wr(8'h13, {3'h0, ~opts[1], 1'b0, accel, 2'h0});
    endtask
endmodule // hpc_host

// ---- hpc_pkg.sv ----
// Purpose: constants for the haptic playback control register slice
// Assumes: byte-wide register port fed by the serial-bus front end on core_clk
// Notes:   offsets are byte register addresses
package hpc_pkg;
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 8;

    // register addresses
    localparam logic [7:0] OFS_CORE_CFG    = 8'h13;
    localparam logic [7:0] OFS_KP_HI       = 8'h1c;
    localparam logic [7:0] OFS_KP_LO       = 8'h1d;
    localparam logic [7:0] OFS_KI_HI       = 8'h1e;
    localparam logic [7:0] OFS_KI_LO       = 8'h1f;
    localparam logic [7:0] OFS_THRESH      = 8'h20;
    localparam logic [7:0] OFS_MODE_CTL    = 8'h22;
    localparam logic [7:0] OFS_OVERRIDE    = 8'h23;
    localparam logic [7:0] OFS_SEQ_OPT     = 8'h24;

    // reset values
    localparam logic [7:0] RST_KP_HI       = 8'h0e;
    localparam logic [7:0] RST_KP_LO       = 8'h20;
    localparam logic [7:0] RST_KI_HI       = 8'h03;
    localparam logic [7:0] RST_KI_LO       = 8'h20;
    localparam logic [2:0] RST_BRAKE_CUT   = 3'h4;
    localparam logic [3:0] RST_TRACK_PAUSE = 4'h3;
    localparam logic [7:0] RST_OVERRIDE    = 8'h00;

    // field positions
    localparam int unsigned BIT_LOOP_EN    = 4;
    localparam int unsigned BIT_ACCEL_EN   = 2;
    localparam int unsigned BIT_GO         = 4;
    localparam int unsigned BIT_STANDBY    = 3;
    localparam int unsigned MODE_LSB       = 0;
    localparam int unsigned BRAKE_LSB      = 4;
    localparam int unsigned TRACK_LSB      = 0;
    localparam int unsigned BIT_TIMEBASE   = 2;
    localparam int unsigned BIT_WAVE       = 1;
    localparam int unsigned BIT_CHAIN      = 0;

    // override codes
    localparam logic [7:0] OVR_MOST_NEG    = 8'h80;
    localparam logic [7:0] OVR_MINUS_ONE   = 8'h81;

    // shortest frame time of each timebase, in microseconds
    localparam logic [13:0] FRAME_BASE_SLOW_US = 14'h1540; // 5.44 ms
    localparam logic [13:0] FRAME_BASE_FAST_US = 14'h0550; // 1.36 ms

    typedef enum logic [2:0] {
        HPC_MODE_INACTIVE = 3'b000,
        HPC_MODE_OVERRIDE = 3'b001,
        HPC_MODE_PWM      = 3'b010,
        HPC_MODE_REG_MEM  = 3'b011,
        HPC_MODE_EDGE_MEM = 3'b100
    } hpc_mode_t;
endpackage

// ---- hpc_regs.sv ----
// Purpose: configuration and playback control registers of a haptic driver
// Assumes: register port pulses come from logic on core_clk
// Notes:   read data appears one cycle after the read strobe
module hpc_regs (
    // clock and reset
    input  wire logic                      core_clk,
    input  wire logic                      rstn,
    // register port
    input  wire logic                      reg_wr,
    input  wire logic                      reg_rd,
    input  wire logic [hpc_pkg::ADDR_W-1:0] reg_addr,
    input  wire logic [hpc_pkg::DATA_W-1:0] reg_wdata,
    output logic      [hpc_pkg::DATA_W-1:0] reg_rdata,
    // sequencer and drive stage
    input  wire logic                      seq_done,
    input  wire logic [7:0]                absolute_max_drive,
    input  wire logic [7:0]                nominal_max_drive,
    // loop settings
    output logic      [15:0]               prop_gain,
    output logic      [15:0]               integ_gain,
    output logic      [2:0]                brake_cutoff_threshold,
    output logic      [3:0]                tracking_pause_threshold,
    output logic                           loop_compute_enable,
    output logic                           accel_enable,
    // mode decode
    output logic                           direct_override_mode,
    output logic                           pwm_input_mode,
    output logic                           register_triggered_memory_mode,
    output logic                           edge_triggered_memory_mode,
    // playback control
    output logic                           playback_go,
    output logic                           playback_start_pulse,
    output logic                           seq_stop_pulse,
    output logic                           enter_standby_pulse,
    output logic                           enter_idle_pulse,
    output logic                           custom_wave_select,
    output logic                           frame_timebase_select,
    output logic      [13:0]               frame_base_us,
    // direct override drive
    output logic      [7:0]                override_factor,
    output logic      [7:0]                drive_limit
);
    import hpc_pkg::*;

    typedef struct packed {
        logic [7:0]  kp_hi;
        logic [7:0]  kp_lo;
        logic [7:0]  ki_hi;
        logic [7:0]  ki_lo;
        logic [2:0]  brake;
        logic [3:0]  track;
        logic        loop_en;
        logic        accel_en;
        logic        go;
        logic        standby;
        logic [2:0]  mode;
        logic [7:0]  override_value;
        logic        timebase;
        logic        wave;
        logic        sequence_chain;
        logic [7:0]  rdata;
        logic        start_p;
        logic        stop_p;
        logic        standby_p;
        logic        idle_p;
        logic [3:0]  mode_hot;
        logic [7:0]  factor;
        logic [7:0]  limit;
        logic [13:0] frame_us;
    } hpc_state_t;

    hpc_state_t s_q;
    hpc_state_t s_d;

    localparam hpc_state_t RST_STATE = '{
        kp_hi: RST_KP_HI, kp_lo: RST_KP_LO, ki_hi: RST_KI_HI, ki_lo: RST_KI_LO,
        brake: RST_BRAKE_CUT, track: RST_TRACK_PAUSE, loop_en: 1'b1, accel_en: 1'b1,
        go: 1'b0, standby: 1'b0, mode: HPC_MODE_INACTIVE, override_value: RST_OVERRIDE,
        timebase: 1'b0, wave: 1'b0, sequence_chain: 1'b0, rdata: 8'h00,
        start_p: 1'b0, stop_p: 1'b0, standby_p: 1'b0, idle_p: 1'b0, mode_hot: 4'h0,
        factor: RST_OVERRIDE, limit: 8'h00, frame_us: FRAME_BASE_SLOW_US
    };

    logic       memory_mode;
    logic       chain_now;
    logic       wr_go;

    always_comb begin
        s_d = s_q;
        s_d.start_p   = 1'b0;
        s_d.stop_p    = 1'b0;
        s_d.standby_p = 1'b0;
        s_d.idle_p    = 1'b0;
        memory_mode = (s_q.mode == HPC_MODE_REG_MEM) || (s_q.mode == HPC_MODE_EDGE_MEM);
        chain_now   = seq_done && s_q.go && memory_mode && s_q.sequence_chain;
        wr_go       = reg_wr && (reg_addr == OFS_MODE_CTL);

        // end of a sequence: chain on, or fall back to idle/standby
        if (seq_done && s_q.go) begin
            if (chain_now) begin
                s_d.sequence_chain = 1'b0;
                s_d.start_p        = 1'b1;
            end else begin
                s_d.go        = 1'b0;
                s_d.standby_p = s_q.standby;
                s_d.idle_p    = ~s_q.standby;
            end
        end

        // register writes; a host write after the hardware update wins
        if (reg_wr) begin
            case (reg_addr)
                OFS_CORE_CFG: begin
                    s_d.loop_en  = reg_wdata[BIT_LOOP_EN];
                    s_d.accel_en = reg_wdata[BIT_ACCEL_EN];
                end
                OFS_KP_HI: s_d.kp_hi = reg_wdata;
                OFS_KP_LO: s_d.kp_lo = reg_wdata;
                OFS_KI_HI: s_d.ki_hi = reg_wdata;
                OFS_KI_LO: s_d.ki_lo = reg_wdata;
                OFS_THRESH: begin
                    s_d.brake = reg_wdata[BRAKE_LSB +: 3];
                    s_d.track = reg_wdata[TRACK_LSB +: 4];
                end
                OFS_MODE_CTL: begin
                    s_d.go      = reg_wdata[BIT_GO];
                    s_d.standby = reg_wdata[BIT_STANDBY];
                    s_d.mode    = reg_wdata[MODE_LSB +: 3];
                end
                OFS_OVERRIDE: s_d.override_value = reg_wdata;
                OFS_SEQ_OPT: begin
                    s_d.timebase = reg_wdata[BIT_TIMEBASE];
                    s_d.wave     = reg_wdata[BIT_WAVE];
                    // a host set in the clearing cycle is kept
                    s_d.sequence_chain = reg_wdata[BIT_CHAIN];
                end
                default: ;
            endcase
        end

        // playback go written: start on 1, stop and idle on 0
        if (wr_go) begin
            if (reg_wdata[BIT_GO]) begin
                s_d.start_p = 1'b1;
                s_d.idle_p  = 1'b0;
                s_d.standby_p = 1'b0;
            end else begin
                // a stop write cancels a chained start in the same cycle
                s_d.start_p   = 1'b0;
                s_d.stop_p    = 1'b1;
                s_d.idle_p    = 1'b1;
                s_d.standby_p = 1'b0;
            end
        end

        // read mux, undefined bits zero
        s_d.rdata = 8'h00;
        if (reg_rd) begin
            case (reg_addr)
                OFS_CORE_CFG: begin
                    s_d.rdata[BIT_LOOP_EN]  = s_q.loop_en;
                    s_d.rdata[BIT_ACCEL_EN] = s_q.accel_en;
                end
                OFS_KP_HI: s_d.rdata = s_q.kp_hi;
                OFS_KP_LO: s_d.rdata = s_q.kp_lo;
                OFS_KI_HI: s_d.rdata = s_q.ki_hi;
                OFS_KI_LO: s_d.rdata = s_q.ki_lo;
                OFS_THRESH: begin
                    s_d.rdata[BRAKE_LSB +: 3] = s_q.brake;
                    s_d.rdata[TRACK_LSB +: 4] = s_q.track;
                end
                OFS_MODE_CTL: begin
                    s_d.rdata[BIT_GO]         = s_q.go;
                    s_d.rdata[BIT_STANDBY]    = s_q.standby;
                    s_d.rdata[MODE_LSB +: 3]  = s_q.mode;
                end
                OFS_OVERRIDE: s_d.rdata = s_q.override_value;
                OFS_SEQ_OPT: begin
                    s_d.rdata[BIT_TIMEBASE] = s_q.timebase;
                    s_d.rdata[BIT_WAVE]     = s_q.wave;
                    s_d.rdata[BIT_CHAIN]    = s_q.sequence_chain;
                end
                default: s_d.rdata = 8'h00;
            endcase
        end

        // mode decode; reserved codes act as inactive
        case (s_d.mode)
            HPC_MODE_OVERRIDE: s_d.mode_hot = 4'h1;
            HPC_MODE_PWM:      s_d.mode_hot = 4'h2;
            HPC_MODE_REG_MEM:  s_d.mode_hot = 4'h4;
            HPC_MODE_EDGE_MEM: s_d.mode_hot = 4'h8;
            default:       s_d.mode_hot = 4'h0;
        endcase

        // override factor: 8'h80 maps to 8'h81, other negatives pass, all negatives go to 0 when accelerating
        if (s_d.override_value[7]) begin
            if (s_d.accel_en) begin
                s_d.factor = 8'h00;
            end else if (s_d.override_value == OVR_MOST_NEG) begin
                s_d.factor = OVR_MINUS_ONE;
            end else begin
                s_d.factor = s_d.override_value;
            end
        end else begin
            s_d.factor = s_d.override_value;
        end
        s_d.limit = s_d.accel_en ? absolute_max_drive : nominal_max_drive;

        s_d.frame_us = s_d.timebase ? FRAME_BASE_FAST_US : FRAME_BASE_SLOW_US;
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            s_q <= RST_STATE;
        end else begin
            s_q <= s_d;
        end
    end

    assign reg_rdata                      = s_q.rdata;
    assign prop_gain                      = {s_q.kp_hi, s_q.kp_lo};
    assign integ_gain                     = {s_q.ki_hi, s_q.ki_lo};
    assign brake_cutoff_threshold         = s_q.brake;
    assign tracking_pause_threshold       = s_q.track;
    assign loop_compute_enable            = s_q.loop_en;
    assign accel_enable                   = s_q.accel_en;
    assign direct_override_mode           = s_q.mode_hot[0];
    assign pwm_input_mode                 = s_q.mode_hot[1];
    assign register_triggered_memory_mode = s_q.mode_hot[2];
    assign edge_triggered_memory_mode     = s_q.mode_hot[3];
    assign playback_go                    = s_q.go;
    assign playback_start_pulse           = s_q.start_p;
    assign seq_stop_pulse                 = s_q.stop_p;
    assign enter_standby_pulse            = s_q.standby_p;
    assign enter_idle_pulse               = s_q.idle_p;
    assign custom_wave_select             = s_q.wave;
    assign frame_timebase_select          = s_q.timebase;
    assign frame_base_us                  = s_q.frame_us;
    assign override_factor                = s_q.factor;
    assign drive_limit                    = s_q.limit;
endmodule // hpc_regs

// ---- hpc_regs_asserts.sv ----
// Purpose: port-level checks of the haptic playback control registers
// Assumes: one clock domain, rstn asynchronous and active low
// Notes:   bound to every hpc_regs instance
module hpc_regs_asserts (
    // clock, reset, register port, sequencer and drive stage
    input wire logic        core_clk, rstn, reg_wr, reg_rd, seq_done,
    input wire logic [7:0]  reg_addr, reg_wdata, reg_rdata, absolute_max_drive, nominal_max_drive,
    // settings and status
    input wire logic [15:0] prop_gain, integ_gain,
    input wire logic [2:0]  brake_cutoff_threshold,
    input wire logic [3:0]  tracking_pause_threshold,
    input wire logic        accel_enable, direct_override_mode, pwm_input_mode,
    input wire logic        register_triggered_memory_mode, edge_triggered_memory_mode,
    input wire logic        playback_go, playback_start_pulse, seq_stop_pulse, enter_standby_pulse, enter_idle_pulse,
    input wire logic        frame_timebase_select,
    input wire logic [13:0] frame_base_us,
    input wire logic [7:0]  override_factor, drive_limit
);
    timeunit 1ns;
    timeprecision 1ps;
    logic mode_wr;
    assign mode_wr = reg_wr && reg_addr == 8'h22;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rstn);
    a_unmapped_read: assert property (
        reg_rd && reg_addr == 8'h21 |=> reg_rdata == 8'h00) else $error("unmapped read not zero");
    a_kp_hi_write: assert property (
        reg_wr && reg_addr == 8'h1c |=> prop_gain[15:8] == $past(reg_wdata)) else $error("gain high byte");
    a_ki_lo_write: assert property (
        reg_wr && reg_addr == 8'h1f |=> integ_gain[7:0] == $past(reg_wdata)) else $error("gain low byte");
    a_thresh_write: assert property (
        reg_wr && reg_addr == 8'h20 |=> {brake_cutoff_threshold, tracking_pause_threshold} == $past(reg_wdata[6:0]))
        else $error("threshold fields");
    a_go_start: assert property (
        mode_wr && reg_wdata[4] |=> playback_start_pulse && playback_go ##1 !playback_start_pulse)
        else $error("start pulse");
    a_go_stop: assert property (
        mode_wr && !reg_wdata[4] && playback_go |=> seq_stop_pulse && enter_idle_pulse && !playback_go)
        else $error("stop pulse");
    a_done_ignored: assert property (
        seq_done && !playback_go && !mode_wr |=> !(playback_start_pulse || enter_idle_pulse || enter_standby_pulse))
        else $error("done while stopped acted");
    a_mode_decode: assert property (
        mode_wr |=> {direct_override_mode, pwm_input_mode, register_triggered_memory_mode, edge_triggered_memory_mode}
        == {$past(reg_wdata[2:0]) == 3'h1, $past(reg_wdata[2:0]) == 3'h2,
            $past(reg_wdata[2:0]) == 3'h3, $past(reg_wdata[2:0]) == 3'h4}) else $error("mode decode");
    a_drive_limit: assert property (
        $past(rstn) |-> drive_limit == (accel_enable ? $past(absolute_max_drive) : $past(nominal_max_drive)))
        else $error("drive limit choice");
    a_override_sign: assert property (
        !(accel_enable && override_factor[7]) && override_factor != 8'h80) else $error("override factor sign");
    a_frame_base: assert property (
        frame_base_us == (frame_timebase_select ? 14'h0550 : 14'h1540)) else $error("frame base time");
    c_start: cover property (playback_start_pulse && playback_go);
    c_standby: cover property (enter_standby_pulse);
    c_edge_mode: cover property (edge_triggered_memory_mode);
endmodule // hpc_regs_asserts

bind hpc_regs hpc_regs_asserts u_asserts (.*);

// ---- hpc_regs_test.sv ----
// Purpose: self-checking bench of the haptic playback control registers
// Assumes: host model drives the register port, bench drives the rest
// Notes:   random writes mixed with override, mode and playback corners
module hpc_regs_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk = 1'b0, rstn = 1'b0, seq_done = 1'b0;
    logic [7:0] absolute_max_drive = 8'h00, nominal_max_drive = 8'h00, rdv;
    logic reg_wr, reg_rd, loop_compute_enable, accel_enable, direct_override_mode, pwm_input_mode;
    logic register_triggered_memory_mode, edge_triggered_memory_mode, playback_go, playback_start_pulse;
    logic seq_stop_pulse, enter_standby_pulse, enter_idle_pulse, custom_wave_select, frame_timebase_select;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, override_factor, drive_limit;
    logic [15:0] prop_gain, integ_gain;
    logic [2:0] brake_cutoff_threshold;
    logic [3:0] tracking_pause_threshold;
    logic [13:0] frame_base_us;
    int fail_count = 0, checked = 0;
    logic [31:0] seed = 32'h5b43996f;
    logic [7:0] ofs [8] = '{8'h13, 8'h1c, 8'h1d, 8'h1e, 8'h1f, 8'h20, 8'h23, 8'h24};
    logic [7:0] rst [8] = '{8'h14, 8'h0e, 8'h20, 8'h03, 8'h20, 8'h43, 8'h00, 8'h00};
    logic [7:0] msk [8] = '{8'h14, 8'hff, 8'hff, 8'hff, 8'hff, 8'h7f, 8'hff, 8'h07};
    logic [7:0] cv [4] = '{8'h7f, 8'h80, 8'h81, 8'h00};
    logic [7:0] m [8];

    hpc_regs u_dut (.*);
    hpc_host u_host (.*);

    initial forever #5 core_clk = ~core_clk;

    function logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic logic [7:0] exp_factor(input logic [7:0] v, input logic acc);
        if (acc && v[7]) return 8'h00;
        if (v == 8'h80) return 8'h81;
        return v;
    endfunction
    task chk(input string n, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e) begin
            $display("MISMATCH %s expected %h seen %h", n, e, g);
            fail_count++;
        end
    endtask
    task close_out;
        if (fail_count == 0 && checked > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // write one mapped register, read it back, compare the gain, level, factor and limit ports
    task put(input int i, input logic [7:0] v);
        u_host.wr(ofs[i], v);
        m[i] = v & msk[i];
        absolute_max_drive <= 8'(xs());
        nominal_max_drive <= 8'(xs());
        u_host.rd(ofs[i], rdv);
        chk("readback", m[i], rdv);
        chk("gains", {m[1], m[2], m[3], m[4]}, {prop_gain, integ_gain});
        chk("levels", {m[5][6:0], m[0][4], m[0][2]},
            {brake_cutoff_threshold, tracking_pause_threshold, loop_compute_enable, accel_enable});
        chk("factor", exp_factor(m[6], m[0][2]), override_factor);
        chk("limit", m[0][2] ? absolute_max_drive : nominal_max_drive, drive_limit);
    endtask
    task done_pulse;
        @(posedge core_clk) seq_done <= 1'b1;
        @(posedge core_clk) seq_done <= 1'b0;
        #1;
    endtask

    initial begin
        repeat (12) @(posedge core_clk);
        rstn <= 1'b1;
        m = rst;
        for (int i = 0; i < 8; i++) begin
            u_host.rd(ofs[i], rdv);
            chk("reset value", rst[i], rdv);
        end
        u_host.wr(8'h21, 8'hff);
        u_host.rd(8'h21, rdv);
        chk("unmapped", 8'h00, rdv);
        for (int k = 0; k < 8; k++) begin
            put(0, k[2] ? 8'h14 : 8'h10);
            put(6, cv[k % 4]);
        end
        for (int n = 0; n < 150; n++) put(int'(xs() % 8), 8'(xs()));
        for (int k = 0; k < 8; k++) begin
            u_host.wr(8'h22, 8'(k));
            #1 chk("mode", {k == 1, k == 2, k == 3, k == 4},
                {direct_override_mode, pwm_input_mode, register_triggered_memory_mode, edge_triggered_memory_mode});
        end
        for (int k = 0; k < 4; k++) begin
            u_host.set_wave({5'h0, k[1], k[0], 1'b0}, 1'b1);
            #1 chk("wave", {k[1] ? 14'h0550 : 14'h1540, k[1], k[0], ~k[0]},
                {frame_base_us, frame_timebase_select, custom_wave_select, loop_compute_enable});
        end
        u_host.wr(8'h24, 8'h01);
        u_host.wr(8'h22, 8'h13);
        #1 chk("start", 2'b11, {playback_start_pulse, playback_go});
        done_pulse();
        chk("chained", 3'b110, {playback_start_pulse, playback_go, enter_idle_pulse});
        u_host.rd(8'h24, rdv);
        chk("chain cleared", 8'h00, rdv);
        done_pulse();
        chk("idle return", 3'b001, {playback_go, enter_standby_pulse, enter_idle_pulse});
        done_pulse();
        chk("done ignored", 2'b00, {playback_start_pulse, enter_idle_pulse});
        u_host.wr(8'h22, 8'h1b);
        done_pulse();
        chk("standby return", 3'b010, {playback_go, enter_standby_pulse, enter_idle_pulse});
        u_host.wr(8'h22, 8'h14);
        u_host.wr(8'h22, 8'h04);
        #1 chk("stop", 3'b011, {playback_go, seq_stop_pulse, enter_idle_pulse});
        close_out();
    end

    initial begin
        #200000;
        fail_count++;
        close_out();
    end
endmodule // hpc_regs_test
